// >>> core/omc_mode_ctrl.sv
// operating mode control: mode latch, mode control register, debug state
// assumes avalon-mm master with byte addresses; pins synchronous to i_core_clk
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
module omc_mode_ctrl #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   output logic      [31:0]       o_avs_readdata,
   output logic                   o_avs_waitrequest,
   // mode pins, captured at reset release
   input  wire logic              i_background_debug_pin,
   input  wire logic              i_mode_select_b,
   input  wire logic              i_mode_select_a,
   // debug events and core status
   input  wire logic              i_bdm_enable_cmd,
   input  wire logic              i_bdm_serial_enter,
   input  wire logic              i_background_entry_instruction,
   input  wire logic              i_bdm_exit,
   input  wire logic              i_serial_access,
   input  wire logic [15:0]       i_cpu_addr,
   input  wire logic              i_wait_mode,
   input  wire logic              i_ext_bus_busy,
   // mode and bus configuration
   output logic                   o_special_mode,
   output logic                   o_single_chip,
   output logic                   o_expanded_narrow,
   output logic                   o_expanded_wide,
   output logic                   o_peripheral,
   output logic                   o_cpu_halt,
   output logic                   o_port_a_addr_data,
   output logic                   o_port_b_addr,
   output logic                   o_port_b_data,
   output logic                   o_split_word_access,
   output logic                   o_bus_clock_stretch,
   output logic                   o_internal_visibility,
   output logic                   o_vis_wide_data,
   output logic                   o_ext_bus_shutdown,
   output logic                   o_port_e_regs_mapped,
   // debug mapping
   output logic                   o_bdm_active,
   output logic                   o_bdm_vectors,
   output logic                   o_sel_bdm_rom,
   output logic                   o_sel_bdm_regs,
   output logic                   o_user_top_hidden
);
   import omc_pkg::*;

   // permission check shared by every protected bit
   function automatic logic wr_ok(input omc_wr_t pol, input logic done);
      unique case (pol)
         OMC_WR_ANY:   wr_ok = 1'b1;
         OMC_WR_ONCE:  wr_ok = !done;
         OMC_WR_SKIP1: wr_ok = done;
         OMC_WR_NEVER: wr_ok = 1'b0;
      endcase
   endfunction

   // register state
   logic       special_n_q;
   logic [1:0] mode_q;
   logic       stretch_q;
   logic       vis_q;
   logic       wait_stop_q;
   logic       emu_e_q;
   logic       dbg_en_q;
   logic       dbg_act_q;
   // first-write tracking per protected field
   logic       done_sp_q;
   logic       done_md_q;
   logic       done_st_q;
   logic       done_vis_q;
   logic       done_emu_q;
   logic [3:0] stop_cnt_q;

   // decoded mode from the live register
   logic special;
   logic single;
   logic periph;
   logic expanded;
   assign special  = !special_n_q;
   assign single   = (mode_q == OMC_MODE_SINGLE);
   assign periph   = (mode_q == OMC_MODE_PERIPH);
   assign expanded = !single && !periph;

   // bus decode; a write is committed only when waitrequest is low
   logic       req;
   logic       hit_mode;
   logic       hit_dbg;
   logic       wr_mode;
   logic       wr_dbg;
   logic [7:0] wd;
   assign req      = i_avs_read || i_avs_write;
   assign hit_mode = (i_avs_address == ADDR_W'({OMC_IDX_MODE, 2'b00})) && !periph;
   assign hit_dbg  = (i_avs_address == ADDR_W'({OMC_IDX_DEBUG, 2'b00}));
   assign wd       = i_avs_writedata[7:0];
   assign wr_mode  = i_avs_write && !o_avs_waitrequest && hit_mode && i_avs_byteenable[0];
   assign wr_dbg   = i_avs_write && !o_avs_waitrequest && hit_dbg && i_avs_byteenable[0];

   // per-field policies chosen by current mode
   logic ok_sp;
   logic ok_md;
   logic ok_st;
   logic ok_vis;
   logic ok_ws;
   logic ok_emu;
   assign ok_sp  = wr_ok(special ? OMC_WR_SKIP1 : OMC_WR_NEVER, done_sp_q);
   assign ok_md  = wr_ok(special ? OMC_WR_SKIP1 : OMC_WR_ONCE, done_md_q)
                   && (wd[OMC_BIT_MODE_B:OMC_BIT_MODE_A] != OMC_MODE_PERIPH);
   assign ok_st  = wr_ok(special ? OMC_WR_ANY : OMC_WR_ONCE, done_st_q);
   assign ok_vis = wr_ok(special ? OMC_WR_SKIP1 : OMC_WR_ONCE, done_vis_q);
   assign ok_ws  = wr_ok(special ? OMC_WR_NEVER : OMC_WR_ANY, 1'b0);
   assign ok_emu = wr_ok(special ? OMC_WR_SKIP1 : OMC_WR_ONCE, done_emu_q);

   // mode bits: pins captured while reset holds, last value kept at release
   // the reserved pin code lands on the peripheral code, which no write reaches
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         special_n_q <= i_background_debug_pin;
         mode_q      <= {i_mode_select_b, i_mode_select_a};
         if (i_background_debug_pin && {i_mode_select_b, i_mode_select_a} == OMC_MODE_PERIPH)
            special_n_q <= 1'b0;
      end else if (wr_mode) begin
         // peripheral mode is unmapped, so it cannot be left here; ok_md refuses the peripheral code, so it cannot be entered either
         if (ok_sp)
            special_n_q <= wd[OMC_BIT_SPECIAL_N];
         if (ok_md)
            mode_q <= wd[OMC_BIT_MODE_B:OMC_BIT_MODE_A];
      end
   end

   // configuration bits; vis and emu reset values follow the captured mode, stretch and wait-stop reset to constants
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         stretch_q   <= OMC_RST_STRETCH;
         vis_q       <= !i_background_debug_pin ||
                        ({i_mode_select_b, i_mode_select_a} == OMC_MODE_PERIPH);
         emu_e_q     <= !i_background_debug_pin ||
                        ({i_mode_select_b, i_mode_select_a} == OMC_MODE_PERIPH);
         wait_stop_q <= OMC_RST_WAIT_STOP;
      end else if (wr_mode) begin
         if (ok_st)
            stretch_q <= wd[OMC_BIT_STRETCH];
         if (ok_vis)
            vis_q <= wd[OMC_BIT_VIS];
         if (ok_ws)
            wait_stop_q <= wd[OMC_BIT_WAIT_STOP];
         if (ok_emu)
            emu_e_q <= wd[OMC_BIT_EMU_E];
      end
   end

   // first-write tracking; any write to the register counts for every field
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         done_sp_q  <= 1'b0;
         done_md_q  <= 1'b0;
         done_st_q  <= 1'b0;
         done_vis_q <= 1'b0;
         done_emu_q <= 1'b0;
      end else if (wr_mode) begin
         done_sp_q  <= 1'b1;
         done_md_q  <= 1'b1;
         done_st_q  <= 1'b1;
         done_vis_q <= 1'b1;
         done_emu_q <= 1'b1;
      end
   end

   // debug enable and active; set events win over clears in the same cycle
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         dbg_en_q  <= !i_background_debug_pin &&
                      ({i_mode_select_b, i_mode_select_a} == OMC_MODE_SINGLE);
         dbg_act_q <= !i_background_debug_pin &&
                      ({i_mode_select_b, i_mode_select_a} == OMC_MODE_SINGLE);
      end else begin
         if (i_bdm_enable_cmd)
            dbg_en_q <= 1'b1;
         else if (wr_dbg)
            dbg_en_q <= wd[OMC_DBG_BIT_ENABLE];
         if (dbg_en_q && (i_bdm_serial_enter || i_background_entry_instruction))
            dbg_act_q <= 1'b1;
         else if (i_bdm_exit || !dbg_en_q)
            dbg_act_q <= 1'b0;
      end
   end

   // wait-mode shutdown waits for the bus to go idle, then a fixed delay
   // so the last external cycle is not cut off
   always_ff @(posedge i_core_clk) begin
      if (i_rst || !(wait_stop_q && i_wait_mode) || i_ext_bus_busy)
         stop_cnt_q <= 4'h0;
      else if (stop_cnt_q != 4'(OMC_WAIT_STOP_CYC))
         stop_cnt_q <= stop_cnt_q + 4'h1;
   end

   // avalon slave: one wait state, read data valid when waitrequest drops
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0000_0000;
      end else begin
         o_avs_waitrequest <= !(req && o_avs_waitrequest);
         if (i_avs_read && o_avs_waitrequest) begin
            o_avs_readdata <= 32'h0000_0000;       // unmapped reads give zero
            if (hit_mode) begin
               o_avs_readdata[OMC_BIT_SPECIAL_N]             <= special_n_q;
               o_avs_readdata[OMC_BIT_MODE_B:OMC_BIT_MODE_A] <= mode_q;
               o_avs_readdata[OMC_BIT_STRETCH]   <= stretch_q || expanded;
               o_avs_readdata[OMC_BIT_VIS]       <= vis_q;
               o_avs_readdata[OMC_BIT_WAIT_STOP] <= wait_stop_q;
               o_avs_readdata[OMC_BIT_EMU_E]     <= emu_e_q;
            end else if (hit_dbg) begin
               o_avs_readdata[OMC_DBG_BIT_ENABLE] <= dbg_en_q;
               o_avs_readdata[OMC_DBG_BIT_ACTIVE] <= dbg_act_q;
               o_avs_readdata[OMC_DBG_BIT_SINGLE] <= single;
               o_avs_readdata[OMC_DBG_BIT_EXPAND] <= expanded;
               o_avs_readdata[OMC_DBG_BIT_WIDE]   <= (mode_q == OMC_MODE_WIDE);
               o_avs_readdata[OMC_DBG_BIT_PERIPH] <= periph;
            end
         end
      end
   end

   // mode and bus configuration outputs, one cycle behind the register
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_special_mode        <= 1'b0;
         o_single_chip         <= 1'b0;
         o_expanded_narrow     <= 1'b0;
         o_expanded_wide       <= 1'b0;
         o_peripheral          <= 1'b0;
         o_cpu_halt            <= 1'b1;
         o_port_a_addr_data    <= 1'b0;
         o_port_b_addr         <= 1'b0;
         o_port_b_data         <= 1'b0;
         o_split_word_access   <= 1'b0;
         o_bus_clock_stretch   <= OMC_RST_STRETCH;
         o_internal_visibility <= 1'b0;
         o_vis_wide_data       <= 1'b0;
         o_ext_bus_shutdown    <= 1'b0;
         o_port_e_regs_mapped  <= 1'b1;
      end else begin
         o_special_mode        <= special;
         o_single_chip         <= single;
         o_expanded_narrow     <= (mode_q == OMC_MODE_NARROW);
         o_expanded_wide       <= (mode_q == OMC_MODE_WIDE);
         o_peripheral          <= periph;
         o_cpu_halt            <= periph;
         o_port_a_addr_data    <= !single;
         o_port_b_addr         <= !single;
         o_port_b_data         <= (mode_q == OMC_MODE_WIDE) || periph;
         o_split_word_access   <= (mode_q == OMC_MODE_NARROW);
         o_bus_clock_stretch   <= stretch_q || expanded;
         o_internal_visibility <= vis_q && expanded;
         o_vis_wide_data       <= vis_q && special && (mode_q == OMC_MODE_NARROW);
         o_ext_bus_shutdown    <= (stop_cnt_q == 4'(OMC_WAIT_STOP_CYC));
         o_port_e_regs_mapped  <= !periph && !(emu_e_q && expanded);
      end
   end

   // debug memory window decode, registered
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_bdm_active      <= 1'b0;
         o_bdm_vectors     <= 1'b0;
         o_sel_bdm_rom     <= 1'b0;
         o_sel_bdm_regs    <= 1'b0;
         o_user_top_hidden <= 1'b0;
      end else begin
         o_bdm_active      <= dbg_act_q;
         o_bdm_vectors     <= dbg_act_q;
         o_sel_bdm_rom     <= dbg_act_q && (i_cpu_addr >= OMC_DBG_ROM_BASE);
         o_sel_bdm_regs    <= dbg_act_q && (i_cpu_addr >= OMC_DBG_REG_BASE)
                              && (i_cpu_addr <= OMC_DBG_REG_LAST);
         o_user_top_hidden <= dbg_act_q && (i_cpu_addr >= OMC_DBG_REG_BASE)
                              && !i_serial_access;
      end
   end

   // checks
   property p_capture;
      @(posedge i_core_clk) $fell(i_rst) |->
         mode_q == ((!$past(i_background_debug_pin) || !$past(i_mode_select_b)
                     || $past(i_mode_select_a)) ? {$past(i_mode_select_b),
                     $past(i_mode_select_a)} : OMC_MODE_PERIPH);
   endproperty
   a_capture: assert property (p_capture) else $error("mode bits not captured");

   property p_forced_periph;
      @(posedge i_core_clk) $fell(i_rst) && $past(i_background_debug_pin)
         && $past(i_mode_select_b) && !$past(i_mode_select_a) |-> !special_n_q;
   endproperty
   a_forced_periph: assert property (p_forced_periph) else $error("reserved not forced");

   property p_no_periph_write;
      @(posedge i_core_clk) disable iff (i_rst)
         !$past(i_rst) && $past(mode_q) != OMC_MODE_PERIPH |-> mode_q != OMC_MODE_PERIPH;
   endproperty
   a_no_periph_write: assert property (p_no_periph_write) else $error("periph selected");

   property p_special_n_normal;
      @(posedge i_core_clk) disable iff (i_rst)
         !$past(i_rst) && $past(special_n_q) |-> special_n_q;
   endproperty
   a_special_n_normal: assert property (p_special_n_normal) else $error("smode bit changed");

   property p_ws_special_never;
      @(posedge i_core_clk) disable iff (i_rst)
         !$past(i_rst) && !$past(special_n_q) |-> $stable(wait_stop_q);
   endproperty
   a_ws_special_never: assert property (p_ws_special_never) else $error("wait-stop written");

   property p_single_no_bus;
      @(posedge i_core_clk) disable iff (i_rst)
         o_single_chip |-> !o_port_a_addr_data && !o_port_b_addr && !o_internal_visibility;
   endproperty
   a_single_no_bus: assert property (p_single_no_bus) else $error("bus in single chip");

   property p_stretch_forced;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_expanded_narrow || o_expanded_wide) |-> o_bus_clock_stretch;
   endproperty
   a_stretch_forced: assert property (p_stretch_forced) else $error("stretch not forced");

   property p_wait_answer;
      @(posedge i_core_clk) disable iff (i_rst)
         req && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("no bus answer");

   property p_periph_unmapped;
      @(posedge i_core_clk) disable iff (i_rst)
         i_avs_read && !o_avs_waitrequest && periph && $stable(i_avs_address)
         && i_avs_address == ADDR_W'({OMC_IDX_MODE, 2'b00}) |-> o_avs_readdata == 32'h0;
   endproperty
   a_periph_unmapped: assert property (p_periph_unmapped) else $error("mode reg mapped");

   property p_rom_map;
      @(posedge i_core_clk) disable iff (i_rst)
         dbg_act_q && i_cpu_addr >= OMC_DBG_ROM_BASE |=> o_sel_bdm_rom
         && (o_user_top_hidden || $past(i_serial_access));
   endproperty
   a_rom_map: assert property (p_rom_map) else $error("debug rom not mapped");

   property p_activate;
      @(posedge i_core_clk) disable iff (i_rst)
         $rose(dbg_act_q) |-> $past(dbg_en_q) &&
         ($past(i_bdm_serial_enter) || $past(i_background_entry_instruction));
   endproperty
   a_activate: assert property (p_activate) else $error("debug active without cause");

endmodule

// >>> common/omc_pkg.sv
// constants, types and register map of the operating mode control block
// assumes a single 25 MHz core clock and a 32-bit avalon-mm slave port
package omc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] OMC_IDX_MODE   = 8'h0b;
   localparam logic [7:0] OMC_IDX_DEBUG  = 8'h0c;
   // operating_mode_control field positions
   localparam int OMC_BIT_SPECIAL_N  = 7;
   localparam int OMC_BIT_MODE_B     = 6;
   localparam int OMC_BIT_MODE_A     = 5;
   localparam int OMC_BIT_STRETCH    = 4;
   localparam int OMC_BIT_VIS        = 3;
   localparam int OMC_BIT_WAIT_STOP  = 2;
   localparam int OMC_BIT_EMU_E      = 0;
   // debug control register field positions
   localparam int OMC_DBG_BIT_ENABLE = 0;
   localparam int OMC_DBG_BIT_ACTIVE = 1;
   localparam int OMC_DBG_BIT_SINGLE = 2;
   localparam int OMC_DBG_BIT_EXPAND = 3;
   localparam int OMC_DBG_BIT_WIDE   = 4;
   localparam int OMC_DBG_BIT_PERIPH = 5;
   // reset values of the plain bits; OMC_RST_DBG_EN is unused, dbg_en_q resets from the pins
   localparam logic OMC_RST_STRETCH   = 1'b1;
   localparam logic OMC_RST_WAIT_STOP = 1'b0;
   localparam logic OMC_RST_DBG_EN    = 1'b0;
   // mode bit pair codes
   localparam logic [1:0] OMC_MODE_SINGLE = 2'h0;
   localparam logic [1:0] OMC_MODE_NARROW = 2'h1;
   localparam logic [1:0] OMC_MODE_PERIPH = 2'h2;
   localparam logic [1:0] OMC_MODE_WIDE   = 2'h3;
   // debug memory window
   localparam logic [15:0] OMC_DBG_ROM_BASE = 16'hff20;
   localparam logic [15:0] OMC_DBG_REG_BASE = 16'hff00;
   localparam logic [15:0] OMC_DBG_REG_LAST = 16'hff06;
   // timing
   localparam int OMC_CLK_PERIOD_NS   = 40;
   localparam int OMC_WAIT_STOP_NS    = 200;
   localparam int OMC_WAIT_STOP_CYC   = (OMC_WAIT_STOP_NS + OMC_CLK_PERIOD_NS - 1)
                                        / OMC_CLK_PERIOD_NS;
   // write policy of a protected bit
   typedef enum logic [1:0] {OMC_WR_ANY, OMC_WR_ONCE, OMC_WR_SKIP1, OMC_WR_NEVER} omc_wr_t;
endpackage

// >>> dv/omc_emu_model.sv
// emulator on the expanded bus: drives cpu address, bus busy, debug entry
// assumes the bench hands it addresses and entry requests at clock edges
`timescale 1ns/1ns
module omc_emu_model (
   // clock and status
   input  wire logic        i_core_clk,
   input  wire logic        i_periph,
   // requests from the bench
   input  wire logic [15:0] i_addr,
   input  wire logic        i_enter_req,
   // toward the block
   output logic      [15:0] o_cpu_addr,
   output logic             o_busy,
   output logic             o_enter
);
   logic [1:0] hold_q;
   // busy two cycles after an address change so last bus activity finishes
   always_ff @(posedge i_core_clk) begin
      o_cpu_addr <= i_addr;
      // case equality so the unknown start address counts as a change, not as x
      hold_q     <= (i_addr !== o_cpu_addr) ? 2'h2 : hold_q - {1'b0, hold_q != 2'h0};
   end
   assign o_busy  = (hold_q != 2'h0);
   // no debug entry in peripheral mode: bus conflict with debug logic
   assign o_enter = i_enter_req & ~i_periph;
endmodule

// >>> dv/operating_mode_control_tb_top.sv
// self-checking bench for the operating mode control block
// assumes avalon answers after waitrequest low; emulator model in omc_emu_model
`timescale 1ns/1ns
module operating_mode_control_tb_top;
   import omc_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, en_cmd = 1'b0, ent = 1'b0;
   logic        ex = 1'b0, ser = 1'b0, wt = 1'b0, busy, ent_o, sc, per, halt, bus_clock_stretch_en, shut;
   logic        act, vec, rom, rgs, hid;
   logic [2:0]  pins = 3'h4;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0, rdat, d;
   logic [15:0] ca = 16'h0000, cpu_a;
   logic        wreq;
   logic        sen = 1'b0;
   wire  [9:0]  cfg;
   int          errors = 0, checks = 0;
   logic [7:0]  tbl [8] = '{8'h19, 8'h39, 8'h00, 8'h79, 8'h90, 8'hb0, 8'h00, 8'hf0};

   initial forever #20 clk = ~clk;

   omc_mode_ctrl omc_mode_ctrl_inst (.i_core_clk(clk), .i_rst(rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_background_debug_pin(pins[2]),
      .i_mode_select_b(pins[1]), .i_mode_select_a(pins[0]), .i_bdm_enable_cmd(en_cmd),
      .i_bdm_serial_enter(sen), .i_background_entry_instruction(ent_o), .i_bdm_exit(ex),
      .i_serial_access(ser), .i_cpu_addr(cpu_a), .i_wait_mode(wt), .i_ext_bus_busy(busy),
      .o_special_mode(cfg[9]), .o_single_chip(sc), .o_expanded_narrow(cfg[8]),
      .o_expanded_wide(cfg[7]), .o_peripheral(per), .o_cpu_halt(halt),
      .o_port_a_addr_data(cfg[6]), .o_port_b_addr(cfg[5]), .o_port_b_data(cfg[4]),
      .o_split_word_access(cfg[3]), .o_bus_clock_stretch(bus_clock_stretch_en),
      .o_internal_visibility(cfg[2]), .o_vis_wide_data(cfg[1]), .o_ext_bus_shutdown(shut),
      .o_port_e_regs_mapped(cfg[0]), .o_bdm_active(act), .o_bdm_vectors(vec),
      .o_sel_bdm_rom(rom), .o_sel_bdm_regs(rgs), .o_user_top_hidden(hid));

   omc_emu_model omc_emu_model_inst (.i_core_clk(clk), .i_periph(per), .i_addr(ca),
      .i_enter_req(ent), .o_cpu_addr(cpu_a), .o_busy(busy), .o_enter(ent_o));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      if (errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
      int n;
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= {24'h0, v};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 16);
      d = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 16) begin
         errors++;
         end_sim();
      end
   endtask

   task automatic reset_to(input logic [2:0] p);
      @(posedge clk);
      rst <= 1'b1;
      pins <= p;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // every pin code: latched value, unmapping and mode flags
   task automatic t_table();
      logic [1:0] m;
      logic       s;
      for (int i = 0; i < 8; i++) begin
         reset_to(i[2:0]);
         bus(1'b0, 8'h2c, 8'h00);
         chk(d, {24'h0, tbl[i]});
         chk(32'({per, halt, sc, act}), 32'({i[1:0] == 2'h2, i[1:0] == 2'h2,
             i[1:0] == 2'h0, i == 0}));
         // reserved pins come up as special peripheral
         m = i[1:0];
         s = !i[2] || m == OMC_MODE_PERIPH;
         chk(32'(cfg), 32'({s, m == 2'h1, m == 2'h3, m != 2'h0, m != 2'h0, m[1],
             m == 2'h1, s && m[0], s && m == 2'h1,
             m != 2'h2 && !(s && m[0])}));
      end
   endtask

   // normal mode write-once fields, then wait shutdown delay
   task automatic t_normal();
      int n;
      reset_to(3'h4);
      bus(1'b1, 8'h2c, 8'h80);
      bus(1'b1, 8'h2c, 8'h1d);
      bus(1'b0, 8'h2c, 8'h00);
      chk(d, 32'h84);
      chk(32'(bus_clock_stretch_en), 32'h0);
      wt <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (shut !== 1'b1 && n < 12);
      chk(32'(n), 32'(OMC_WAIT_STOP_CYC + 2));
      wt <= 1'b0;
   endtask

   // special mode: first write skipped, peripheral code refused
   task automatic t_special();
      reset_to(3'h0);
      bus(1'b1, 8'h2c, 8'h04);
      bus(1'b0, 8'h2c, 8'h00);
      chk(d, 32'h09);
      bus(1'b1, 8'h2c, 8'h44);
      bus(1'b0, 8'h2c, 8'h00);
      chk(d, 32'h00);
      bus(1'b1, 8'h2c, 8'h60);
      bus(1'b0, 8'h2c, 8'h00);
      chk(d, 32'h70);
      // leave special mode by software, then only wait-stop stays open
      bus(1'b1, 8'h2c, 8'he0);
      bus(1'b0, 8'h2c, 8'h00);
      chk(d, 32'hf0);
      bus(1'b1, 8'h2c, 8'h1d);
      bus(1'b0, 8'h2c, 8'h00);
      chk(d, 32'hf4);
   endtask

   // debug needs enabling first, then maps its rom and registers
   task automatic t_debug();
      reset_to(3'h4);
      ca <= 16'hffff;
      ent <= 1'b1;
      @(posedge clk);
      ent <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'(act), 32'h0);
      en_cmd <= 1'b1;
      @(posedge clk);
      en_cmd <= 1'b0;
      ent <= 1'b1;
      @(posedge clk);
      ent <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'({act, vec, rom, rgs, hid}), 32'h1d);
      ca <= 16'hff03;
      ser <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'({rom, rgs, hid}), 32'h2);
      bus(1'b0, 8'h30, 8'h00);
      chk(d, 32'h07);
      bus(1'b0, 8'h40, 8'h00);
      chk(d, 32'h00);
      ex <= 1'b1;
      @(posedge clk);
      ex <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(act), 32'h0);
      // serial entry path, then software clears enable and active follows
      sen <= 1'b1;
      @(posedge clk);
      sen <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(act), 32'h1);
      bus(1'b1, 8'h30, 8'h00);
      repeat (3) @(posedge clk);
      chk(32'(act), 32'h0);
      bus(1'b0, 8'h30, 8'h00);
      chk(d, 32'h04);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      t_table();
      t_normal();
      t_special();
      t_debug();
      end_sim();
   end
endmodule
